// ### shared/brc_pkg.sv
// Purpose: shared constants for the board reset and indicator control block
// Assumes: 100 MHz system clock, all pins synchronous to it
// Notes: times are kept in their own unit, cycle counts derived from them
package brc_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 100; // system clock rate
  localparam int unsigned WDOG_TIMEOUT_MS = 900; // least watchdog time-out
  localparam int unsigned RELAY_TIMEOUT_MS = 600; // relay monostable time-out
  // least time rounds up (exact here), ms * 1000 us * MHz
  localparam int unsigned WDOG_CYCLES = WDOG_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned RELAY_CYCLES = RELAY_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned WDOG_RST_CYCLES = 16; // length of a watchdog reset pulse
  // ----------------------------------------
  // indicator latch
  // ----------------------------------------
  localparam int unsigned LED_WIDTH = 8; // latch width
  localparam logic [7:0] LED_RESET = 8'hFF; // all indicators dark after reset
  // ----------------------------------------
  // processor pin numbers
  // ----------------------------------------
  localparam int unsigned PIN_PERIPH_RST = 8; // pci and switch reset release
  localparam int unsigned PIN_ERASE = 9; // erase button input
  localparam int unsigned PIN_RETRIGGER = 10; // watchdog retrigger
  localparam int unsigned PIN_TEL_RST = 13; // telephony reset
  localparam int unsigned PIN_COUNT = 16; // number of processor pins
endpackage

// ### design/brc_monostable.sv
// Purpose: retriggerable time-out counter
// Assumes: retrig is a one-cycle pulse in clk_sys domain
// Notes: expired rises when no retrigger has been seen for TIMEOUT cycles
`timescale 1ns/100ps
module brc_monostable #(
  parameter int unsigned TIMEOUT = 1000 // cycles until expiry
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic arm, // counting allowed
  input wire logic retrig, // restart the period
  output logic expired // period ran out
);
  // ----------------------------------------
  // counter
  // ----------------------------------------
  localparam int unsigned CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT);
  logic [CW-1:0] cnt_r; // cycles since last retrigger

  // refused at elaboration: a one-cycle period cannot tell retrigger from expiry
  if (TIMEOUT < 2) begin : g_bad_timeout
    $error("brc_monostable: TIMEOUT must be at least 2");
  end

  // counter saturates at the limit so expiry stays until retriggered or disarmed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (!arm || retrig) begin
        cnt_r <= '0; // restart window
      end else if (cnt_r != LIMIT) begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

  assign expired = arm && (cnt_r == LIMIT);

  // no expiry in the cycle right after a retrigger
  no_early_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && retrig) |=> !expired) else $error("monostable expired right after retrigger");
endmodule

// ### design/brc_board_ctrl.sv
// Purpose: board reset distribution, watchdog, relay, erase button, indicator latch
// Assumes: processor pins and expansion-bus strobes are synchronous to clk_sys
// Notes: indicator latch is write-only, its readback bus is held at zero
`timescale 1ns/100ps
// Function
// - eight-bit indicator latch, write only, no readback
// - stored zero lights indicator, one leaves dark
// - latch captures only with its chip select
// - power-on reset resets whole board
// - manual link resets board like power-on
// - peripherals held reset until pin 8 high output
// - watchdog acts only with enable link fitted
// - watchdog resets system without retrigger in 0.9s
// - erase button pulls pin 9 low when pressed
// - retrigger pin also feeds 600 ms relay monostable
module brc_board_ctrl
  import brc_pkg::*;
#(
  parameter int unsigned WDOG_TIMEOUT = WDOG_CYCLES, // watchdog time-out in cycles
  parameter int unsigned RELAY_TIMEOUT = RELAY_CYCLES, // relay time-out in cycles
  parameter int unsigned WDOG_PULSE = WDOG_RST_CYCLES // watchdog reset pulse length
) (
  input wire logic clk_sys,
  input wire logic rst_n, // power-on reset, supplies valid when high
  input wire logic clk_en,
  input wire logic manual_reset_link_n, // low while link shorted
  input wire logic watchdog_enable_link_n, // low while link fitted
  input wire logic erase_switch_n, // low while button pressed
  input wire logic [PIN_COUNT-1:0] gpio_out, // processor pin output levels
  input wire logic [PIN_COUNT-1:0] gpio_dir_out, // high where pin is an output
  input wire logic indicator_latch_select_n, // expansion-bus chip select
  input wire logic bus_wr_n, // expansion-bus write strobe
  input wire logic bus_rd_n, // expansion-bus read strobe
  input wire logic [7:0] bus_wdata, // expansion-bus write data
  output logic [7:0] bus_rdata, // read data, never the latch
  output logic [PIN_COUNT-1:0] gpio_in, // levels seen at processor inputs
  output logic [LED_WIDTH-1:0] led_n, // indicators, low lights
  output logic board_rst_n, // whole-board reset
  output logic periph_rst_n, // pci and switch reset
  output logic tel_rst_n, // telephony line interface reset
  output logic relay_hold // line-failover relay energised
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // pulse counter is eight bits wide, so longer pulses are refused
  if (WDOG_PULSE < 1 || WDOG_PULSE > 255) begin : g_bad_pulse
    $error("brc_board_ctrl: WDOG_PULSE out of range");
  end
  if (LED_WIDTH != 8) begin : g_bad_latch
    $error("brc_board_ctrl: latch must be 8 bits");
  end

  // ----------------------------------------
  // board reset
  // ----------------------------------------
  logic man_sync1_r; // first stage, read only by second
  logic man_sync2_r; // synchronised manual link, high when shorted
  logic wdog_fire; // watchdog expiry
  logic [7:0] wdog_pulse_r; // remaining cycles of watchdog reset
  logic board_rst_r; // registered board reset, active high

  // manual link synchroniser, reset to the pressed state so board starts held
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      man_sync1_r <= 1'b1;
      man_sync2_r <= 1'b1;
    end else if (clk_en) begin
      man_sync1_r <= !manual_reset_link_n;
      man_sync2_r <= man_sync1_r;
    end
  end

  // watchdog reset stretch so the board sees a clean pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdog_pulse_r <= 8'h00;
    end else if (clk_en) begin
      if (wdog_fire && wdog_pulse_r == 8'h00) begin
        wdog_pulse_r <= 8'(WDOG_PULSE);
      end else if (wdog_pulse_r != 8'h00) begin
        wdog_pulse_r <= wdog_pulse_r - 8'h01;
      end
    end
  end

  // power-on holds via async reset, manual link and watchdog join synchronously
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      board_rst_r <= 1'b1;
    end else if (clk_en) begin
      board_rst_r <= man_sync2_r || (wdog_pulse_r != 8'h00);
    end
  end

  assign board_rst_n = !board_rst_r;

  // ----------------------------------------
  // peripheral and telephony resets
  // ----------------------------------------
  logic periph_rst_r; // pci and switch reset, active high
  logic tel_rst_r; // telephony reset, active high

  // pin must be both an output and high, so a floating input keeps reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      periph_rst_r <= 1'b1;
    end else if (clk_en) begin
      periph_rst_r <= board_rst_r ||
        !(gpio_dir_out[PIN_PERIPH_RST] && gpio_out[PIN_PERIPH_RST]);
    end
  end

  // telephony reset follows pin 13 the same way; release timing is software's
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tel_rst_r <= 1'b1;
    end else if (clk_en) begin
      tel_rst_r <= board_rst_r ||
        !(gpio_dir_out[PIN_TEL_RST] && gpio_out[PIN_TEL_RST]);
    end
  end

  assign periph_rst_n = !periph_rst_r;
  assign tel_rst_n = !tel_rst_r;

  // ----------------------------------------
  // watchdog and relay
  // ----------------------------------------
  logic retrig_last_r; // previous retrigger level
  logic retrig_edge; // either edge of retrigger pin
  logic wdog_arm; // watchdog enable link fitted and board out of reset
  logic relay_exp; // relay monostable expired

  // either edge counts, the processor toggles the pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      retrig_last_r <= 1'b0;
    end else if (clk_en) begin
      retrig_last_r <= gpio_out[PIN_RETRIGGER];
    end
  end

  assign retrig_edge = gpio_out[PIN_RETRIGGER] != retrig_last_r;
  // watchdog sleeps during its own reset pulse so it restarts cleanly
  assign wdog_arm = !watchdog_enable_link_n && !board_rst_r;

  brc_monostable #(
    .TIMEOUT(WDOG_TIMEOUT)
  ) u_wdog (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .arm(wdog_arm),
    .retrig(retrig_edge),
    .expired(wdog_fire)
  );

  // relay runs whatever the enable link says
  brc_monostable #(
    .TIMEOUT(RELAY_TIMEOUT)
  ) u_relay (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .arm(!board_rst_r),
    .retrig(retrig_edge),
    .expired(relay_exp)
  );

  // relay drops on expiry or board reset, failing the line over
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      relay_hold <= 1'b0;
    end else if (clk_en) begin
      relay_hold <= !board_rst_r && !relay_exp;
    end
  end

  // ----------------------------------------
  // erase button and pin inputs
  // ----------------------------------------
  // button passed raw: bounce filtering is processor software's job
  always_comb begin
    gpio_in = '0;
    gpio_in[PIN_ERASE] = erase_switch_n;
  end

  // ----------------------------------------
  // indicator latch
  // ----------------------------------------
  logic [LED_WIDTH-1:0] led_r; // stored latch bits

  // captures only on a write with its own chip select
  // any board reset darkens the latch, writes during it are lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      led_r <= LED_RESET;
    end else if (clk_en) begin
      if (board_rst_r) begin
        led_r <= LED_RESET;
      end else if (!indicator_latch_select_n && !bus_wr_n) begin
        led_r <= bus_wdata;
      end
    end
  end

  assign led_n = led_r;
  assign bus_rdata = 8'h00;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence wr_seq;
    clk_en && !board_rst_r && !indicator_latch_select_n && !bus_wr_n;
  endsequence

  latch_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_seq |=> led_n == $past(bus_wdata)) else $error("latch missed write");
  latch_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!clk_en || (indicator_latch_select_n && !board_rst_r)) |=> $stable(led_n))
    else $error("latch changed");
  latch_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && board_rst_r) |=> led_n == LED_RESET) else $error("latch kept on reset");
  no_readback_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !bus_rd_n |-> bus_rdata == 8'h00) else $error("latch read back");
  manual_rst_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !manual_reset_link_n)[*3] |=> !board_rst_n) else $error("link no reset");
  periph_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !gpio_dir_out[PIN_PERIPH_RST]) |=> !periph_rst_n)
    else $error("peripheral reset released");
  tel_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !gpio_out[PIN_TEL_RST]) |=> !tel_rst_n) else $error("telephony reset lost");
  wdog_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && watchdog_enable_link_n && wdog_pulse_r == 8'h00) |=> wdog_pulse_r == 8'h00)
    else $error("watchdog fired unfitted");
  wdog_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && wdog_fire && wdog_pulse_r == 8'h00) ##1 clk_en |=> !board_rst_n)
    else $error("watchdog did not reset");
  relay_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && relay_exp) |=> !relay_hold) else $error("relay held on expiry");
endmodule

// ### verif/brc_cpu_model.sv
// Purpose: processor pin and expansion-bus model
// Assumes: drives on the falling edge of clk_sys
// Notes: released write data shows the inverse of its last value
`timescale 1ns/100ps
module brc_cpu_model
  import brc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] bus_rdata, // bus read data, never the latch
  output logic [PIN_COUNT-1:0] gpio_out, // pin levels
  output logic [PIN_COUNT-1:0] gpio_dir_out, // pin directions
  output logic sel_n, // latch chip select
  output logic wr_n, // write strobe
  output logic rd_n, // read strobe
  output logic [7:0] wdata // write data
);
  // ----------------------------------------
  // idle bus, retrigger pin set as output
  // ----------------------------------------
  initial begin
    gpio_out = '0;
    gpio_dir_out = 16'h0400;
    sel_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    wdata = 8'h00;
  end
  // one write; s_n high makes an unselected write
  task automatic bus_wr(input logic s_n, input logic [7:0] d);
    @(negedge clk_sys);
    sel_n = s_n;
    wr_n = 1'b0;
    wdata = d;
    @(negedge clk_sys);
    sel_n = 1'b1;
    wr_n = 1'b1;
    wdata = ~d; // no stale value after release
  endtask
  // one selected read, data taken at the next rising clock edge after the strobe falls
  task automatic bus_rd(output logic [7:0] q);
    @(negedge clk_sys);
    sel_n = 1'b0;
    rd_n = 1'b0;
    @(posedge clk_sys);
    q = bus_rdata;
    @(negedge clk_sys);
    sel_n = 1'b1;
    rd_n = 1'b1;
  endtask
  // sets one pin's direction and level at the next falling edge, whatever the board reset
  task automatic set_pin(input int idx, input logic dir, input logic v);
    @(negedge clk_sys);
    gpio_dir_out[idx] = dir;
    gpio_out[idx] = v;
  endtask
  // one retrigger edge, either direction counts
  task automatic kick();
    @(negedge clk_sys);
    gpio_out[PIN_RETRIGGER] = ~gpio_out[PIN_RETRIGGER];
  endtask
endmodule

// ### verif/brc_board_ctrl_tb.sv
// Purpose: self-checking bench for the board control block
// Assumes: short watchdog and relay counts for a quick run
// Notes: erase input is raw; filtering is left to software
`timescale 1ns/100ps
module brc_board_ctrl_tb;
  import brc_pkg::*;
  logic clk_sys, rst_n, man_n, wdl_n, erase_n, en; // board-side inputs
  logic sel_n, wr_n, rd_n; // bus strobes from the model
  logic [7:0] wdata, rdata, led_n, q; // bus data and indicators
  logic [PIN_COUNT-1:0] gout, gdir, gpio_in; // processor pins
  logic board_rst_n, periph_rst_n, tel_rst_n, relay_hold; // resets, relay
  int mismatches, checks_done;
  brc_cpu_model CPU (.clk_sys(clk_sys), .bus_rdata(rdata), .gpio_out(gout),
    .gpio_dir_out(gdir), .sel_n(sel_n), .wr_n(wr_n), .rd_n(rd_n), .wdata(wdata));
  brc_board_ctrl #(.WDOG_TIMEOUT(50), .RELAY_TIMEOUT(30), .WDOG_PULSE(16)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(en), .manual_reset_link_n(man_n),
    .watchdog_enable_link_n(wdl_n), .erase_switch_n(erase_n), .gpio_out(gout),
    .gpio_dir_out(gdir), .indicator_latch_select_n(sel_n), .bus_wr_n(wr_n),
    .bus_rd_n(rd_n), .bus_wdata(wdata), .bus_rdata(rdata), .gpio_in(gpio_in),
    .led_n(led_n), .board_rst_n(board_rst_n), .periph_rst_n(periph_rst_n),
    .tel_rst_n(tel_rst_n), .relay_hold(relay_hold));
  // ----------------------------------------
  // clock and shared tasks
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // bounded wait on the board reset, gives up into the verdict
  task automatic wait_board(input logic lvl, input int lim);
    int n;
    n = 0;
    while (board_rst_n !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
    chk(board_rst_n, lvl);
    if (board_rst_n !== lvl) give_verdict();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // walking zero lights each indicator; stray writes and reads
  task automatic t_latch();
    for (int i = 0; i < 8; i++) begin
      CPU.bus_wr(1'b0, ~(8'h01 << i));
      chk(led_n, 8'(~(8'h01 << i)));
    end
    CPU.bus_wr(1'b1, 8'h3C);
    chk(led_n, 8'h7F);
    CPU.bus_rd(q);
    chk(q, 8'h00);
  endtask
  // pin must be output and high to release; low again re-resets
  task automatic t_pin(input int idx);
    logic [2:0] seen;
    CPU.set_pin(idx, 1'b0, 1'b1);
    cyc(3);
    seen[0] = (idx == PIN_PERIPH_RST) ? periph_rst_n : tel_rst_n;
    CPU.set_pin(idx, 1'b1, 1'b1);
    cyc(3);
    seen[1] = (idx == PIN_PERIPH_RST) ? periph_rst_n : tel_rst_n;
    CPU.set_pin(idx, 1'b1, 1'b0);
    cyc(3);
    seen[2] = (idx == PIN_PERIPH_RST) ? periph_rst_n : tel_rst_n;
    chk(seen, 3'b010);
    CPU.set_pin(idx, 1'b1, 1'b1);
  endtask
  // manual link resets the board and the peripherals
  task automatic t_manual();
    man_n = 1'b0;
    cyc(5);
    chk({board_rst_n, periph_rst_n, tel_rst_n, led_n}, 16'h00FF);
    man_n = 1'b1;
    wait_board(1'b1, 10);
    cyc(3);
    chk({periph_rst_n, tel_rst_n}, 2'b11);
  endtask
  // relay follows retriggers; watchdog only with link fitted
  task automatic t_watchdog();
    cyc(40);
    chk({relay_hold, board_rst_n}, 2'b01);
    CPU.kick();
    cyc(3);
    chk(relay_hold, 1'b1);
    cyc(40);
    chk(relay_hold, 1'b0);
    wdl_n = 1'b0;
    for (int i = 0; i < 8; i++) begin
      CPU.kick();
      cyc(20);
      chk(board_rst_n, 1'b1);
    end
    wait_board(1'b0, 80);
    wdl_n = 1'b1;
    wait_board(1'b1, 60);
  endtask
  // erase button reaches pin 9 unfiltered
  task automatic t_erase();
    for (int v = 0; v < 2; v++) begin
      erase_n = v[0];
      cyc(1);
      chk(gpio_in, 16'(v) << PIN_ERASE);
    end
  endtask
  // latch still dark after the watchdog reset; frozen clock enable ignores a write
  task automatic t_freeze();
    chk(led_n, 8'hFF);
    en = 1'b0;
    CPU.bus_wr(1'b0, 8'h5A);
    chk(led_n, 8'hFF);
    en = 1'b1;
    CPU.bus_wr(1'b0, 8'h5A);
    chk(led_n, 8'h5A);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    mismatches = 0;
    checks_done = 0;
    rst_n = 1'b0;
    en = 1'b1;
    man_n = 1'b1;
    wdl_n = 1'b1;
    erase_n = 1'b1;
    cyc(12);
    chk({board_rst_n, relay_hold, led_n}, 16'h00FF);
    rst_n = 1'b1;
    cyc(2);
    chk(board_rst_n, 1'b0);
    wait_board(1'b1, 5);
    t_latch();
    t_pin(PIN_PERIPH_RST);
    t_pin(PIN_TEL_RST);
    t_manual();
    t_watchdog();
    t_freeze();
    t_erase();
    give_verdict();
  end
endmodule
